/* File: rtl/ioacc_core.sv */
`timescale 1ns/10ps
`include "ioacc_defines.svh"

// What this block does
// - I/O read bank 0 port 0..3 returns that general input as 0 or 1.
// - Port 255 of bank 0 loads all general inputs into the accumulator as bits.
// - Every input line reads both digitally and as analog result independently.
// - Bank 1 port 0..3 returns that line's unsigned analog conversion result.
// - Bank 2 port 0..3 returns the last level set on that output.
// - Bank 0 port 10 returns 0 when drive enabled, 1 otherwise.
// - Math command 19 combines accumulator and 32-bit operand, stores result.
// - Type picks add, sub, multiply, divide, remainder, and, or, xor, invert, load.
// - Direct mode math reply carries status 100 on success, 3 or 4 on a bad type or zero divisor; its value means nothing.
// - Compare command 20 sets flags from accumulator versus operand.
// - Standalone I/O reads load the accumulator; direct ones only reply, except bank 0 port 255.
// - Analog reads give 16-bit 0..65535, single-line digital reads only 0 or 1.
module ioacc_core (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic standalone_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    output logic [7:0] tx_byte_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic [3:0] gen_in_i,
    input wire logic [63:0] adc_i,
    input wire logic [3:0] out_state_i,
    input wire logic drive_en_i,
    output logic [31:0] accu_o,
    output logic cmp_eq_o,
    output logic cmp_gt_o,
    output logic cmp_lt_o,
    output logic cmd_done_o
);
    ioacc_cmd_if cif ();
    ioacc_alu_if aif ();

    ioacc_frame_rx u_rx (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .rx_byte_i(rx_byte_i),
        .rx_valid_i(rx_valid_i),
        .rx_ready_o(rx_ready_o),
        .c(cif.rx)
    );

    ioacc_alu u_alu (
        .a(aif.alu)
    );

    ioacc_pkg::ioa_state_t state_reg;
    ioacc_pkg::ioa_state_t state_next;
    logic [7:0] instr_reg;
    logic [7:0] type_reg;
    logic [7:0] bank_reg;
    logic [31:0] opnd_reg;
    logic ok_reg;
    logic alone_reg;
    logic [31:0] accu_reg;
    logic eq_reg;
    logic gt_reg;
    logic lt_reg;
    logic [7:0] status_reg;
    logic [31:0] rval_reg;
    logic [7:0] csum_reg;
    logic [3:0] idx_reg;
    logic [7:0] tx_byte_reg;
    logic tx_valid_reg;
    logic done_reg;

    // Byte of the reply frame at position idx
    function automatic logic [7:0] reply_byte(input logic [3:0] idx, input logic [7:0] st,
                                              input logic [7:0] ins, input logic [31:0] v,
                                              input logic [7:0] cs);
        logic [7:0] b;
        unique case (idx)
            4'h0: b = `IOA_HOST_ADDR;
            4'h1: b = `IOA_MODULE_ADDR;
            4'h2: b = st;
            4'h3: b = ins;
            4'h4: b = v[31:24];
            4'h5: b = v[23:16];
            4'h6: b = v[15:8];
            4'h7: b = v[7:0];
            default: b = cs;
        endcase
        return b;
    endfunction

    // Command acceptance
    logic take;
    assign cif.ready = state_reg == ioacc_pkg::IOA_IDLE;
    assign take = cif.valid && cif.ready;

    // Instruction decode
    logic is_io_rd;
    logic is_math;
    logic is_comp;
    assign is_io_rd = instr_reg == `IOA_INSTR_IO_READ;
    assign is_math = instr_reg == `IOA_INSTR_MATH;
    assign is_comp = instr_reg == `IOA_INSTR_COMP;

    // I/O read selection
    logic [1:0] line;
    logic port_line;
    logic port_all;
    logic port_en;
    logic bank_din;
    logic bank_adc;
    logic bank_dout;
    logic bank_bad;
    logic port_bad;
    logic [15:0] adc_sel;
    logic [31:0] io_val;
    assign line = type_reg[1:0];
    assign port_line = type_reg <= `IOA_PORT_LAST;
    assign port_all = type_reg == `IOA_PORT_ALL;
    assign port_en = type_reg == `IOA_PORT_ENABLE;
    assign bank_din = bank_reg == `IOA_BANK_DIN;
    assign bank_adc = bank_reg == `IOA_BANK_ADC;
    assign bank_dout = bank_reg == `IOA_BANK_DOUT;
    assign bank_bad = !(bank_din || bank_adc || bank_dout);
    assign port_bad = !(port_line || (bank_din && (port_all || port_en)));
    assign adc_sel = adc_i[line*`IOA_ADC_W +: `IOA_ADC_W];

    always_comb begin
        io_val = 32'h0000_0000;
        if (bank_din && port_line) begin
            io_val = {31'h0, gen_in_i[line]};
        end else if (bank_din && port_all) begin
            io_val = {28'h0, gen_in_i};
        end else if (bank_din && port_en) begin
            io_val = {31'h0, !drive_en_i};
        end else if (bank_adc && port_line) begin
            io_val = {16'h0, adc_sel};
        end else if (bank_dout && port_line) begin
            io_val = {31'h0, out_state_i[line]};
        end
    end

    // Accumulator arithmetic
    assign aif.op = type_reg[3:0];
    assign aif.acc = accu_reg;
    assign aif.operand = opnd_reg;
    logic math_bad_type;
    assign math_bad_type = aif.bad_op || (type_reg[7:4] != 4'h0);

    // Compare against the operand as signed numbers
    logic cmp_eq;
    logic cmp_lt;
    assign cmp_eq = accu_reg == opnd_reg;
    assign cmp_lt = $signed(accu_reg) < $signed(opnd_reg);

    // Outcome of the executing command
    logic [7:0] status;
    always_comb begin
        status = `IOA_ST_OK;
        if (!ok_reg) begin
            status = `IOA_ST_BAD_CSUM;
        end else if (!(is_io_rd || is_math || is_comp)) begin
            status = `IOA_ST_BAD_INSTR;
        end else if (is_io_rd && bank_bad) begin
            status = `IOA_ST_BAD_VALUE;
        end else if (is_io_rd && port_bad) begin
            status = `IOA_ST_BAD_TYPE;
        end else if (is_math && math_bad_type) begin
            status = `IOA_ST_BAD_TYPE;
        end else if (is_math && aif.div_zero) begin
            status = `IOA_ST_BAD_VALUE;
        end
    end

    logic good;
    logic io_to_acc;
    logic [31:0] accu_next;
    logic [31:0] rval;
    assign good = status == `IOA_ST_OK;
    // Reading all inputs at once always lands in the accumulator
    assign io_to_acc = is_io_rd && (alone_reg || (bank_din && port_all));
    assign rval = is_io_rd ? io_val : opnd_reg;

    always_comb begin
        accu_next = accu_reg;
        if (good && is_math) begin
            accu_next = aif.result;
        end else if (good && io_to_acc) begin
            accu_next = io_val;
        end
    end

    // Sequencing
    logic exec;
    logic sent;
    logic last_byte;
    assign exec = state_reg == ioacc_pkg::IOA_EXEC;
    assign sent = tx_valid_reg && tx_ready_i;
    assign last_byte = idx_reg == `IOA_LAST_IDX;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ioacc_pkg::IOA_IDLE: if (take) begin
                state_next = ioacc_pkg::IOA_EXEC;
            end
            ioacc_pkg::IOA_EXEC: begin
                // A stored program gets no reply frame
                state_next = alone_reg ? ioacc_pkg::IOA_IDLE : ioacc_pkg::IOA_SEND;
            end
            ioacc_pkg::IOA_SEND: if (sent && last_byte) begin
                state_next = ioacc_pkg::IOA_IDLE;
            end
            default: state_next = ioacc_pkg::IOA_IDLE;
        endcase
    end

    logic [63:0] reply_hdr;
    assign reply_hdr = {`IOA_HOST_ADDR, `IOA_MODULE_ADDR, status, instr_reg, rval};

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= ioacc_pkg::IOA_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            instr_reg <= 8'h00;
            type_reg <= 8'h00;
            bank_reg <= 8'h00;
            opnd_reg <= 32'h0000_0000;
            ok_reg <= 1'b0;
            alone_reg <= 1'b0;
        end else if (take) begin
            instr_reg <= cif.instr;
            type_reg <= cif.ctype;
            bank_reg <= cif.bank;
            opnd_reg <= cif.value;
            ok_reg <= cif.csum_ok;
            alone_reg <= standalone_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            accu_reg <= 32'h0000_0000;
            eq_reg <= 1'b0;
            gt_reg <= 1'b0;
            lt_reg <= 1'b0;
        end else if (exec) begin
            accu_reg <= accu_next;
            if (good && is_comp) begin
                eq_reg <= cmp_eq;
                lt_reg <= cmp_lt;
                gt_reg <= !cmp_eq && !cmp_lt;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_reg <= 8'h00;
            rval_reg <= 32'h0000_0000;
            csum_reg <= 8'h00;
        end else if (exec) begin
            status_reg <= status;
            rval_reg <= rval;
            csum_reg <= ioacc_pkg::frame_sum(reply_hdr);
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            idx_reg <= 4'h0;
            tx_byte_reg <= 8'h00;
            tx_valid_reg <= 1'b0;
        end else if (exec && !alone_reg) begin
            idx_reg <= 4'h0;
            tx_byte_reg <= `IOA_HOST_ADDR;
            tx_valid_reg <= 1'b1;
        end else if (sent) begin
            idx_reg <= idx_reg + 4'h1;
            tx_byte_reg <= reply_byte(idx_reg + 4'h1, status_reg, instr_reg,
                                      rval_reg, csum_reg);
            tx_valid_reg <= !last_byte;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= (exec && alone_reg) || (sent && last_byte);
        end
    end

    assign tx_byte_o = tx_byte_reg;
    assign tx_valid_o = tx_valid_reg;
    assign accu_o = accu_reg;
    assign cmp_eq_o = eq_reg;
    assign cmp_gt_o = gt_reg;
    assign cmp_lt_o = lt_reg;
    assign cmd_done_o = done_reg;
endmodule // ioacc_core

/* File: rtl/ioacc_defines.svh */
`ifndef IOACC_DEFINES_SVH
`define IOACC_DEFINES_SVH

// Frame layout
`define IOA_FRAME_LEN 4'd9
`define IOA_LAST_IDX 4'd8
`define IOA_MODULE_ADDR 8'h01
`define IOA_HOST_ADDR 8'h02

// Instruction codes
`define IOA_INSTR_IO_READ 8'h0f
`define IOA_INSTR_MATH 8'h13
`define IOA_INSTR_COMP 8'h14

// Banks and special ports of the I/O read
`define IOA_BANK_DIN 8'h00
`define IOA_BANK_ADC 8'h01
`define IOA_BANK_DOUT 8'h02
`define IOA_PORT_LAST 8'h03
`define IOA_PORT_ALL 8'hff
`define IOA_PORT_ENABLE 8'h0a

// Accumulator operations
`define IOA_OP_ADD 4'h0
`define IOA_OP_SUB 4'h1
`define IOA_OP_MULTIPLY 4'h2
`define IOA_OP_DIV 4'h3
`define IOA_OP_REMAINDER 4'h4
`define IOA_OP_AND 4'h5
`define IOA_OP_OR 4'h6
`define IOA_OP_XOR 4'h7
`define IOA_OP_NOT 4'h8
`define IOA_OP_LOAD 4'h9

// Reply status codes
`define IOA_ST_OK 8'h64
`define IOA_ST_BAD_CSUM 8'h01
`define IOA_ST_BAD_INSTR 8'h02
`define IOA_ST_BAD_TYPE 8'h03
`define IOA_ST_BAD_VALUE 8'h04

`define IOA_ADC_W 16
`define IOA_LINES 4

`endif

/* File: rtl/ioacc_pkg.sv */
package ioacc_pkg;

    typedef enum logic [1:0] {
        IOA_IDLE = 2'b00,
        IOA_EXEC = 2'b01,
        IOA_SEND = 2'b11
    } ioa_state_t;

    typedef logic [31:0] ioa_word_t;

    // Modulo-256 sum of the eight leading bytes of a frame
    function automatic logic [7:0] frame_sum(input logic [63:0] hdr);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 8; i++) begin
            s = s + hdr[i*8 +: 8];
        end
        return s;
    endfunction

endpackage

/* File: rtl/ioacc_if.sv */
`timescale 1ns/10ps

// Decoded command handed from the frame receiver to the core
interface ioacc_cmd_if;
    logic valid;
    logic ready;
    logic csum_ok;
    logic [7:0] instr;
    logic [7:0] ctype;
    logic [7:0] bank;
    logic [31:0] value;
    modport rx (output valid, csum_ok, instr, ctype, bank, value, input ready);
    modport core (input valid, csum_ok, instr, ctype, bank, value, output ready);
endinterface

// Operands and result of the accumulator arithmetic
interface ioacc_alu_if;
    logic [3:0] op;
    logic [31:0] acc;
    logic [31:0] operand;
    logic [31:0] result;
    logic bad_op;
    logic div_zero;
    modport alu (input op, acc, operand, output result, bad_op, div_zero);
    modport core (output op, acc, operand, input result, bad_op, div_zero);
endinterface

/* File: rtl/ioacc_alu.sv */
`timescale 1ns/10ps
`include "ioacc_defines.svh"

module ioacc_alu (
    ioacc_alu_if.alu a
);
    logic signed [31:0] sa;
    logic signed [31:0] sb;
    logic [63:0] prod;
    logic signed [31:0] quo;
    logic signed [31:0] rem;

    assign sa = a.acc;
    assign sb = a.operand;
    assign prod = 64'(sa * sb);
    assign a.div_zero = (a.operand == 32'h0000_0000) &&
                        ((a.op == `IOA_OP_DIV) || (a.op == `IOA_OP_REMAINDER));
    // Divider sees a safe divisor when a divide or remainder has a zero operand
    assign quo = sa / (a.div_zero ? 32'sh0000_0001 : sb);
    assign rem = sa % (a.div_zero ? 32'sh0000_0001 : sb);
    assign a.bad_op = a.op > `IOA_OP_LOAD;

    always_comb begin
        unique case (a.op)
            `IOA_OP_ADD: a.result = a.acc + a.operand;
            `IOA_OP_SUB: a.result = a.acc - a.operand;
            `IOA_OP_MULTIPLY: a.result = prod[31:0];
            `IOA_OP_DIV: a.result = quo;
            `IOA_OP_REMAINDER: a.result = rem;
            `IOA_OP_AND: a.result = a.acc & a.operand;
            `IOA_OP_OR: a.result = a.acc | a.operand;
            `IOA_OP_XOR: a.result = a.acc ^ a.operand;
            `IOA_OP_NOT: a.result = ~a.acc;
            `IOA_OP_LOAD: a.result = a.operand;
            default: a.result = a.acc;
        endcase
    end
endmodule // ioacc_alu

/* File: rtl/ioacc_frame_rx.sv */
`timescale 1ns/10ps
`include "ioacc_defines.svh"

module ioacc_frame_rx (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    ioacc_cmd_if.rx c
);
    logic [63:0] hdr_reg;
    logic [3:0] cnt_reg;
    logic pend_reg;
    logic ok_reg;
    logic rdy_reg;
    logic take;
    logic last;
    logic mine;

    assign take = rx_valid_i && rdy_reg;
    assign last = cnt_reg == `IOA_LAST_IDX;
    assign mine = hdr_reg[63:56] == `IOA_MODULE_ADDR;

    assign rx_ready_o = rdy_reg;
    assign c.valid = pend_reg;
    assign c.csum_ok = ok_reg;
    assign c.instr = hdr_reg[55:48];
    assign c.ctype = hdr_reg[47:40];
    assign c.bank = hdr_reg[39:32];
    assign c.value = hdr_reg[31:0];

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hdr_reg <= 64'h0;
            cnt_reg <= 4'h0;
        end else if (take) begin
            // Bytes shift in most significant first
            if (!last) begin
                hdr_reg <= {hdr_reg[55:0], rx_byte_i};
            end
            cnt_reg <= last ? 4'h0 : cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_reg <= 1'b0;
            ok_reg <= 1'b0;
            rdy_reg <= 1'b1;
        end else if (take && last && mine) begin
            pend_reg <= 1'b1;
            ok_reg <= rx_byte_i == ioacc_pkg::frame_sum(hdr_reg);
            rdy_reg <= 1'b0;
        end else if (pend_reg && c.ready) begin
            pend_reg <= 1'b0;
            rdy_reg <= 1'b1;
        end
    end
endmodule // ioacc_frame_rx

/* File: bench/ioa_core_properties.sv */
`timescale 1ns/10ps

module ioa_core_chk (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic standalone_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_valid_i,
    input wire logic rx_ready_o,
    input wire logic [7:0] tx_byte_o,
    input wire logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic [3:0] gen_in_i,
    input wire logic [63:0] adc_i,
    input wire logic [3:0] out_state_i,
    input wire logic drive_en_i,
    input wire logic [31:0] accu_o,
    input wire logic cmp_eq_o,
    input wire logic cmp_gt_o,
    input wire logic cmp_lt_o,
    input wire logic cmd_done_o
);
    logic [3:0] rcnt_reg;
    logic [3:0] tcnt_reg;
    logic [7:0] radr_reg;
    logic [7:0] tsum_reg;
    wire logic rx_take = rx_valid_i && rx_ready_o;
    wire logic tx_take = tx_valid_o && tx_ready_i;

    // Byte positions within the command and reply frames
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rcnt_reg <= 4'h0;
            tcnt_reg <= 4'h0;
            radr_reg <= 8'h00;
            tsum_reg <= 8'h00;
        end else begin
            if (rx_take) begin
                rcnt_reg <= (rcnt_reg == 4'h8) ? 4'h0 : rcnt_reg + 4'h1;
                radr_reg <= (rcnt_reg == 4'h0) ? rx_byte_i : radr_reg;
            end
            if (tx_take) begin
                tcnt_reg <= (tcnt_reg == 4'h8) ? 4'h0 : tcnt_reg + 4'h1;
                tsum_reg <= (tcnt_reg == 4'h8) ? 8'h00 : tsum_reg + tx_byte_o;
            end
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence frame_end;
        rx_take && rcnt_reg == 4'h8 && radr_reg == 8'h01;
    endsequence
    sequence reply_end;
        tx_take && tcnt_reg == 4'h8;
    endsequence

    busy_after_frame_a: assert property (frame_end |=> !rx_ready_o)
        else $error("byte link still ready after a full frame");
    drop_foreign_a: assert property (rx_take && rcnt_reg == 4'h8 && radr_reg != 8'h01
        |=> rx_ready_o ##1 !tx_valid_o) else $error("foreign frame was not dropped");
    reply_start_a: assert property (frame_end ##0 !standalone_i
        |-> ##3 (tx_valid_o && tx_byte_o == 8'h02)) else $error("reply start wrong");
    reply_hold_a: assert property (tx_valid_o && !tx_ready_i
        |=> tx_valid_o && $stable(tx_byte_o)) else $error("reply byte not held");
    reply_addr_a: assert property (tx_valid_o && tcnt_reg == 4'h1 |-> tx_byte_o == 8'h01)
        else $error("reply module address wrong");
    reply_sum_a: assert property (tx_valid_o && tcnt_reg == 4'h8 |-> tx_byte_o == tsum_reg)
        else $error("reply checksum wrong");
    reply_done_a: assert property (reply_end |=> cmd_done_o ##1 (!cmd_done_o && rx_ready_o))
        else $error("command end after reply wrong");
    standalone_quiet_a: assert property (frame_end ##0 standalone_i
        |=> (!tx_valid_o throughout ##[1:3] cmd_done_o)) else $error("standalone reply or late");
    flags_excl_a: assert property ($onehot0({cmp_eq_o, cmp_gt_o, cmp_lt_o}))
        else $error("compare flags not exclusive");
    accu_quiet_a: assert property ($changed(accu_o) |-> !$past(rx_ready_o, 2))
        else $error("accumulator changed outside a command");
endmodule // ioa_core_chk

bind ioacc_core ioa_core_chk u_chk (.ref_clk_i, .nrst_i, .standalone_i, .rx_byte_i,
    .rx_valid_i, .rx_ready_o, .tx_byte_o, .tx_valid_o, .tx_ready_i, .gen_in_i, .adc_i,
    .out_state_i, .drive_en_i, .accu_o, .cmp_eq_o, .cmp_gt_o, .cmp_lt_o, .cmd_done_o);

/* File: bench/ioa_host.sv */
`timescale 1ns/10ps

module ioa_host (
    input wire logic ref_clk_i,
    input wire logic standalone_i,
    input wire logic rx_ready_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_valid_i,
    input wire logic cmd_done_i,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o,
    output logic tx_ready_o
);
    initial begin
        rx_byte_o = 8'h00;
        rx_valid_o = 1'b0;
        tx_ready_o = 1'b0;
    end

    // Sends one frame and collects the reply, first byte in the top bits
    task automatic send(input logic [7:0] adr, ins, typ, bnk, input logic [31:0] v,
                        input int stall, output logic [71:0] rep);
        logic [7:0] f [9];
        f = '{adr, ins, typ, bnk, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
        for (int i = 0; i < 8; i++) f[8] = f[8] + f[i];
        for (int i = 0; i < 9; i++) begin
            rx_byte_o <= f[i];
            rx_valid_o <= 1'b1;
            do @(posedge ref_clk_i); while (rx_ready_i !== 1'b1);
        end
        rx_valid_o <= 1'b0;
        rx_byte_o <= ~f[8];
        rep = '0;
        if (adr != 8'h01) begin
            repeat (4) @(posedge ref_clk_i);
        end else if (standalone_i) begin
            do @(posedge ref_clk_i); while (cmd_done_i !== 1'b1);
        end else begin
            for (int i = 0; i < 9; i++) begin
                if (stall > 0) begin
                    tx_ready_o <= 1'b0;
                    repeat (stall) @(posedge ref_clk_i);
                end
                tx_ready_o <= 1'b1;
                do @(posedge ref_clk_i); while (tx_valid_i !== 1'b1);
                rep = {rep[63:0], tx_byte_i};
            end
            tx_ready_o <= 1'b0;
        end
    endtask
endmodule // ioa_host

/* File: bench/tb_io_read_and_accumulator_ops.sv */
`timescale 1ns/10ps

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end

module tb_io_read_and_accumulator_ops;
    logic ref_clk_i;
    logic nrst_i = 1'b0;
    logic standalone_i = 1'b0;
    logic drive_en_i = 1'b1;
    logic [3:0] gen_in_i = 4'h0;
    logic [3:0] out_state_i = 4'h0;
    logic [63:0] adc_i = 64'h0;
    logic [7:0] rx_byte_i, tx_byte_o;
    logic rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, cmd_done_o;
    logic cmp_eq_o, cmp_gt_o, cmp_lt_o;
    logic [31:0] accu_o;
    logic [31:0] acc_exp = 32'h0;
    logic [71:0] rep;
    int n_fail = 0;
    int check_count = 0;

    ioacc_core dut (.ref_clk_i, .nrst_i, .standalone_i, .rx_byte_i, .rx_valid_i, .rx_ready_o,
        .tx_byte_o, .tx_valid_o, .tx_ready_i, .gen_in_i, .adc_i, .out_state_i, .drive_en_i,
        .accu_o, .cmp_eq_o, .cmp_gt_o, .cmp_lt_o, .cmd_done_o);
    ioa_host host (.ref_clk_i, .standalone_i, .rx_ready_i(rx_ready_o), .tx_byte_i(tx_byte_o),
        .tx_valid_i(tx_valid_o), .cmd_done_i(cmd_done_o), .rx_byte_o(rx_byte_i),
        .rx_valid_o(rx_valid_i), .tx_ready_o(tx_ready_i));

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic run(input logic [7:0] ins, typ, bnk, input logic [31:0] v, input int stall);
        host.send(8'h01, ins, typ, bnk, v, stall, rep);
    endtask

    task automatic reply(input logic [7:0] ins, input logic [31:0] v);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 1; i < 9; i++) s = s + rep[i*8 +: 8];
        `CHK(rep[71:40], {8'h02, 8'h01, 8'h64, ins})
        `CHK(rep[39:8], v)
        `CHK(rep[7:0], s)
    endtask

    task automatic t_din;
        logic [3:0] g;
        for (int k = 0; k < 2; k++) begin
            g = k ? 4'ha : 4'h5;
            @(posedge ref_clk_i);
            gen_in_i <= g;
            for (int p = 0; p < 4; p++) begin
                run(8'h0f, 8'(p), 8'h00, 32'h0, p % 2);
                reply(8'h0f, {31'h0, g[p]});
                `CHK(accu_o, acc_exp)
            end
            run(8'h0f, 8'hff, 8'h00, 32'h0, 0);
            acc_exp = {28'h0, g};
            reply(8'h0f, acc_exp);
            `CHK(accu_o, acc_exp)
            @(posedge ref_clk_i);
            drive_en_i <= k[0];
            run(8'h0f, 8'h0a, 8'h00, 32'h0, 0);
            reply(8'h0f, {31'h0, !k[0]});
        end
    endtask

    task automatic t_adc;
        logic [63:0] a;
        a = 64'hffff_8001_012e_0000;
        @(posedge ref_clk_i);
        adc_i <= a;
        gen_in_i <= 4'h9;
        for (int p = 0; p < 4; p++) begin
            run(8'h0f, 8'(p), 8'h01, 32'h0, 0);
            reply(8'h0f, {16'h0, a[p*16 +: 16]});
            run(8'h0f, 8'(p), 8'h00, 32'h0, 0);
            reply(8'h0f, {31'h0, p == 0 || p == 3});
        end
    endtask

    task automatic t_dout;
        @(posedge ref_clk_i);
        out_state_i <= 4'h6;
        for (int p = 0; p < 4; p++) begin
            run(8'h0f, 8'(p), 8'h02, 32'h0, 2);
            reply(8'h0f, {31'h0, p == 1 || p == 2});
        end
        run(8'h0f, 8'h04, 8'h02, 32'h0, 0);
        `CHK(rep[55:48], 8'h03)
    endtask

    task automatic t_math;
        logic [3:0] op [10] = '{9, 0, 1, 2, 3, 4, 5, 6, 7, 8};
        logic [31:0] v [10] = '{100, 35, 5, -5000, 7, 1000, 'hfff, 'h10000, 'hff, 0};
        logic [31:0] e [10] = '{100, 135, 130, -650000, -92857, -857, 'hca7, 'h10ca7,
                                'h10c58, 'hfffef3a7};
        for (int i = 0; i < 10; i++) begin
            run(8'h13, {4'h0, op[i]}, 8'h00, v[i], i % 3);
            reply(8'h13, v[i]);
            acc_exp = e[i];
            `CHK(accu_o, acc_exp)
        end
        run(8'h13, 8'h03, 8'h00, 32'h0, 0);
        `CHK({rep[55:48], accu_o}, {8'h04, acc_exp})
    endtask

    task automatic t_comp;
        logic [31:0] v [3] = '{0, 32'hfffef3a7, 32'h80000000};
        logic [2:0] f [3] = '{3'b001, 3'b100, 3'b010};
        @(posedge ref_clk_i);
        standalone_i <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            run(8'h14, 8'h00, 8'h00, v[i], 0);
            `CHK({cmp_eq_o, cmp_gt_o, cmp_lt_o}, f[i])
            `CHK(accu_o, acc_exp)
        end
        run(8'h0f, 8'h03, 8'h01, 32'h0, 0);
        acc_exp = 32'h0000ffff;
        `CHK(accu_o, acc_exp)
        host.send(8'h05, 8'h13, 8'h09, 8'h00, 32'h1, 0, rep);
        `CHK(accu_o, acc_exp)
        @(posedge ref_clk_i);
        standalone_i <= 1'b0;
    endtask

    task automatic t_reset;
        @(posedge ref_clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        `CHK({accu_o, rx_ready_o, tx_valid_o, cmp_eq_o, cmp_gt_o}, {32'h0, 4'b1000})
        nrst_i <= 1'b1;
        run(8'h0f, 8'hff, 8'h00, 32'h0, 1);
        reply(8'h0f, 32'h9);
    endtask

    task conclude;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #100us;
        n_fail++;
        conclude;
    end

    initial begin
        repeat (5) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        t_din;
        t_adc;
        t_dout;
        t_math;
        t_comp;
        t_reset;
        conclude;
    end
endmodule // tb_io_read_and_accumulator_ops
